// ===== src/tsq_sequencer.sv
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tsq_sequencer (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // serial pins
  input  wire logic        serial_clock_in,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             conv_busy,
  // analog core
  input  wire logic [11:0] adc_code,
  output logic [2:0]       channel_select,
  output logic             ref_mode_select,
  output logic             sample_hold,
  output logic             x_drv_pos,
  output logic             x_drv_neg,
  output logic             y_drv_pos,
  output logic             y_drv_neg,
  output logic             temp_bias_unit,
  output logic             temp_bias_x91,
  output logic             battery_div_en,
  output logic             adc_power_on,
  output logic             ref_power_on,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------------
  // reset release and pin synchronisation
  // ----------------------------------------------------------------------
  logic        rst_meta_b;
  logic        rst_sync_b;
  logic [1:0]  pins_sync;
  logic        sclk_prev;

  // reset asserts at once, releases two clocks later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  tsq_sync2 u_sync (
    .clk      (clk),
    .rst_b    (rst_sync_b),
    .ce       (ce),
    .pin_in   ({serial_clock_in, serial_data_in}),
    .pin_sync (pins_sync)
  );

  wire sclk_s    = pins_sync[1];
  wire din_s     = pins_sync[0];
  wire sclk_rise = sclk_s & ~sclk_prev;
  wire sclk_fall = ~sclk_s & sclk_prev;

  // ----------------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------------
  tsq_pkg::tsq_state_t state;
  logic [4:0]  edge_cnt;
  logic [6:0]  ctrl_shift;
  logic [7:0]  ctrl_byte;
  logic        res_8bit;
  logic        pwr_field_low;
  logic        pwr_field_high;
  logic [11:0] result_shift;
  logic [11:0] result_last;
  logic [3:0]  bits_left;
  logic [15:0] frame_count;
  logic [1:0]  ctrl_reg;

  wire seq_enable = ctrl_reg[tsq_pkg::CTRL_ENABLE_BIT];
  wire [7:0] byte_now  = {ctrl_shift, din_s};
  wire [2:0] ch_early  = ctrl_shift[2:0]; // start sits above the channel at edge 5
  wire [2:0] ch_now    = byte_now[tsq_pkg::CH_HI:tsq_pkg::CH_LO];
  wire       ser_now   = byte_now[tsq_pkg::REF_MODE_BIT];
  wire       mode_now  = byte_now[tsq_pkg::MODE_BIT];
  wire [4:0] next_edge = edge_cnt + 5'h01;
  wire [4:0] next_ok   = res_8bit ? tsq_pkg::EDGE_NEXT_8 : tsq_pkg::EDGE_NEXT_12;
  wire [4:0] out_edge  = ref_mode_select ? tsq_pkg::EDGE_OUT_SE : tsq_pkg::EDGE_OUT_DIFF;
  wire       restart   = din_s && (next_edge > next_ok);
  wire       frame_end = next_edge == tsq_pkg::EDGE_FRAME_END;
  wire       out_now   = (edge_cnt >= out_edge) && (bits_left != 4'h0);

  // edge history, only the synchronised copy is looked at
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sclk_prev <= 1'b0;
    end else if (ce) begin
      sclk_prev <= sclk_s;
    end
  end

  // frame walk on rising serial clock edges; no edge means no progress
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state      <= tsq_pkg::TSQ_IDLE;
      edge_cnt   <= 5'h00;
      ctrl_shift <= 7'h00;
    end else if (ce && sclk_rise) begin
      ctrl_shift <= byte_now[6:0];
      case (state)
        tsq_pkg::TSQ_IDLE: begin
          if (din_s && seq_enable) begin
            state    <= tsq_pkg::TSQ_CTRL;
            edge_cnt <= tsq_pkg::EDGE_START;
          end
        end
        tsq_pkg::TSQ_CTRL: begin
          edge_cnt <= next_edge;
          if (next_edge == tsq_pkg::EDGE_ACQ) begin
            state <= tsq_pkg::TSQ_ACQ;
          end
        end
        tsq_pkg::TSQ_ACQ: begin
          edge_cnt <= next_edge;
          if (next_edge == tsq_pkg::EDGE_HOLD) begin
            state <= tsq_pkg::TSQ_CONV;
          end
        end
        tsq_pkg::TSQ_CONV: begin
          if (restart) begin
            state    <= tsq_pkg::TSQ_CTRL;
            edge_cnt <= tsq_pkg::EDGE_START;
          end else if (frame_end) begin
            state    <= tsq_pkg::TSQ_IDLE;
            edge_cnt <= 5'h00;
          end else begin
            edge_cnt <= next_edge;
          end
        end
        default: begin
          state    <= tsq_pkg::TSQ_IDLE;
          edge_cnt <= 5'h00;
        end
      endcase
    end
  end

  // control byte latched at the hold edge, applies to this conversion
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl_byte       <= 8'h00;
      channel_select  <= 3'h0;
      ref_mode_select <= 1'b0;
      res_8bit        <= 1'b0;
      pwr_field_low   <= 1'b0;
      pwr_field_high  <= 1'b0;
    end else if (ce && sclk_rise) begin
      if (state == tsq_pkg::TSQ_CTRL && next_edge == tsq_pkg::EDGE_ACQ) begin
        channel_select <= ch_early;
      end
      if (state == tsq_pkg::TSQ_ACQ && next_edge == tsq_pkg::EDGE_HOLD) begin
        ctrl_byte       <= byte_now;
        channel_select  <= ch_now;
        ref_mode_select <= ser_now;
        res_8bit        <= mode_now;
        pwr_field_low   <= byte_now[tsq_pkg::PWR_LOW_BIT];
        pwr_field_high  <= byte_now[tsq_pkg::PWR_HIGH_BIT];
      end
    end
  end

  // result capture at hold and msb first shift on falling edges
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      result_shift    <= 12'h000;
      result_last     <= 12'h000;
      bits_left       <= 4'h0;
      serial_data_out <= 1'b0;
    end else if (ce) begin
      if (sclk_rise && state == tsq_pkg::TSQ_ACQ && next_edge == tsq_pkg::EDGE_HOLD) begin
        result_shift <= mode_now ? {adc_code[11:4], 4'h0} : adc_code;
        result_last  <= mode_now ? {4'h0, adc_code[11:4]} : adc_code;
        bits_left    <= mode_now ? tsq_pkg::RES_8 : tsq_pkg::RES_12;
      end else if (sclk_fall && state == tsq_pkg::TSQ_CONV && out_now) begin
        serial_data_out <= result_shift[11];
        result_shift    <= {result_shift[10:0], 1'b0};
        bits_left       <= bits_left - 4'h1;
      end else if (sclk_fall) begin
        serial_data_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // analog control decode
  // ----------------------------------------------------------------------
  wire in_acq   = state == tsq_pkg::TSQ_ACQ;
  wire in_conv  = state == tsq_pkg::TSQ_CONV;
  wire hold_on  = pwr_field_low && !in_acq && !in_conv;
  wire drv_live = in_acq || (in_conv && !ref_mode_select) || hold_on;
  wire ch_y     = channel_select == tsq_pkg::CH_Y_POS;
  wire ch_x     = channel_select == tsq_pkg::CH_X_POS;
  wire ch_z     = (channel_select == tsq_pkg::CH_Z1) || (channel_select == tsq_pkg::CH_Z2);
  wire idle_pd  = !pwr_field_low && !in_acq && !in_conv;
  wire next_xp  = drv_live && ch_x;
  wire next_xn  = drv_live && (ch_x || ch_z);
  wire next_yp  = drv_live && (ch_y || ch_z);
  wire next_yn  = (drv_live && ch_y) || idle_pd; // pen detect path in power-down
  wire next_tu  = in_acq && channel_select == tsq_pkg::CH_TEMP_UNIT;
  wire next_t91 = in_acq && channel_select == tsq_pkg::CH_TEMP_X91;
  wire next_bat = in_acq && channel_select == tsq_pkg::CH_BATTERY;
  wire next_adc = in_acq || in_conv || pwr_field_low;
  wire next_ref = pwr_field_high;

  // all analog controls registered so the pins never glitch
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      {x_drv_pos, x_drv_neg, y_drv_pos, y_drv_neg} <= 4'h0;
      {temp_bias_unit, temp_bias_x91, battery_div_en} <= 3'h0;
      {adc_power_on, ref_power_on, sample_hold, conv_busy} <= 4'h0;
    end else if (ce) begin
      {x_drv_pos, x_drv_neg, y_drv_pos, y_drv_neg} <= {next_xp, next_xn, next_yp, next_yn};
      {temp_bias_unit, temp_bias_x91, battery_div_en} <= {next_tu, next_t91, next_bat};
      {adc_power_on, ref_power_on} <= {next_adc, next_ref};
      sample_hold <= in_conv;
      conv_busy   <= in_conv;
    end
  end

  // completed frames, a restart by overlap also counts
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      frame_count <= 16'h0000;
    end else if (ce && sclk_rise && in_conv && (restart || frame_end)) begin
      frame_count <= frame_count + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite slave, one write and one read in flight
  // ----------------------------------------------------------------------
  logic [3:0]  aw_addr;
  logic        aw_got;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_got;

  wire do_write = aw_got && w_got && !s_axi_bvalid;
  wire wr_ctrl  = aw_addr == tsq_pkg::REG_CTRL;
  wire wr_err   = !wr_ctrl;
  wire [31:0] stat_word = {16'h0000, ctrl_byte, 2'h0, pwr_field_high, pwr_field_low,
                           2'h0, state};
  wire rd_ctrl  = s_axi_araddr == tsq_pkg::REG_CTRL;
  wire rd_stat  = s_axi_araddr == tsq_pkg::REG_STATUS;
  wire rd_res   = s_axi_araddr == tsq_pkg::REG_RESULT;
  wire rd_frm   = s_axi_araddr == tsq_pkg::REG_FRAMES;
  wire rd_err   = !(rd_ctrl || rd_stat || rd_res || rd_frm);
  wire [31:0] rd_mux = rd_ctrl ? {30'h0000_0000, ctrl_reg} :
                       rd_stat ? stat_word :
                       rd_res  ? {20'h0_0000, result_last} :
                       rd_frm  ? {16'h0000, frame_count} : 32'h0000_0000;

  // address and data channels, taken in either order
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      {s_axi_awready, s_axi_wready, aw_got, w_got} <= 4'h0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (ce) begin
      s_axi_awready <= !aw_got && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_got && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_got <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got  <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_got <= 1'b0;
      end
    end
  end

  // write response and the control register
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= tsq_pkg::RESP_OKAY;
      ctrl_reg     <= tsq_pkg::CTRL_RESET;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? tsq_pkg::RESP_SLVERR : tsq_pkg::RESP_OKAY;
        if (wr_ctrl && w_strb[0]) begin
          ctrl_reg <= w_data[1:0];
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel, unmapped words read zero with slverr
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= tsq_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_err ? tsq_pkg::RESP_SLVERR : tsq_pkg::RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : tsq_sequencer
`default_nettype wire

// ===== pkg/tsq_pkg.sv
`default_nettype none
package tsq_pkg;

  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    TSQ_IDLE,
    TSQ_CTRL,
    TSQ_ACQ,
    TSQ_CONV
  } tsq_state_t;

  // ----------------------------------------------------------------------
  // control byte layout, msb first
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_BITS    = 8;
  localparam int unsigned CH_HI        = 6;
  localparam int unsigned CH_LO        = 4;
  localparam int unsigned MODE_BIT     = 3;
  localparam int unsigned REF_MODE_BIT = 2;
  localparam int unsigned PWR_HIGH_BIT = 1;
  localparam int unsigned PWR_LOW_BIT  = 0;

  // channel codes
  localparam logic [2:0] CH_TEMP_UNIT = 3'h0;
  localparam logic [2:0] CH_Y_POS     = 3'h1;
  localparam logic [2:0] CH_BATTERY   = 3'h2;
  localparam logic [2:0] CH_Z1        = 3'h3;
  localparam logic [2:0] CH_Z2        = 3'h4;
  localparam logic [2:0] CH_X_POS     = 3'h5;
  localparam logic [2:0] CH_TEMP_X91  = 3'h7;

  // ----------------------------------------------------------------------
  // serial clock edge numbers within one frame, counted from the start bit
  // ----------------------------------------------------------------------
  localparam logic [4:0] EDGE_START     = 5'h01;
  localparam logic [4:0] EDGE_ACQ       = 5'h05;
  localparam logic [4:0] ACQ_CYCLES     = 5'h03;
  localparam logic [4:0] EDGE_HOLD      = EDGE_ACQ + ACQ_CYCLES;
  localparam logic [4:0] EDGE_OUT_SE    = 5'h09;
  localparam logic [4:0] EDGE_OUT_DIFF  = 5'h0A;
  localparam logic [4:0] EDGE_FRAME_END = 5'h18;
  localparam logic [4:0] EDGE_NEXT_12   = 5'h0F;
  localparam logic [4:0] EDGE_NEXT_8    = 5'h0B;
  localparam logic [3:0] RES_12         = 4'hC;
  localparam logic [3:0] RES_8          = 4'h8;
  localparam int unsigned RESULT_W      = 12;

  // ----------------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------------
  localparam int unsigned AXI_AW     = 4;
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam logic [3:0]  REG_RESULT = 4'h8;
  localparam logic [3:0]  REG_FRAMES = 4'hC;
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam logic [1:0]  CTRL_RESET      = 2'h1;
  localparam int unsigned STAT_BYTE_LO    = 8;
  localparam int unsigned STAT_PWR_LO     = 4;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage : tsq_pkg
`default_nettype wire

// ===== src/tsq_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for the serial pins; first stage is read by nothing else
module tsq_sync2 (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  // pins in, synchronised copy out
  input  wire logic [1:0] pin_in,
  output logic      [1:0] pin_sync
);

  logic [1:0] stage1;

  // --------------------------------------------------------------------
  // double flop, frozen with the clock enable
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1   <= 2'h0;
      pin_sync <= 2'h0;
    end else if (ce) begin
      stage1   <= pin_in;
      pin_sync <= stage1;
    end
  end

endmodule : tsq_sync2
`default_nettype wire

// ===== testbench/tsq_sequencer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// output relations of the sequencer that hold in every state
module tsq_sequencer_assertions (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // sequencer outputs
  input wire logic       conv_busy,
  input wire logic [2:0] channel_select,
  input wire logic       ref_mode_select,
  input wire logic       sample_hold,
  input wire logic       x_drv_pos,
  input wire logic       x_drv_neg,
  input wire logic       y_drv_pos,
  input wire logic       y_drv_neg,
  input wire logic       temp_bias_unit,
  input wire logic       temp_bias_x91,
  input wire logic       battery_div_en,
  input wire logic       adc_power_on,
  // register read channel
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // driver enables as one nibble, x+ x- y+ y-
  wire logic [3:0] drv = {x_drv_pos, x_drv_neg, y_drv_pos, y_drv_neg};

  AST_BIAS_EXCL: assert property (!(temp_bias_unit && temp_bias_x91))
    else $error("both diode bias levels on");
  AST_UNIT_CH: assert property (temp_bias_unit |-> channel_select == tsq_pkg::CH_TEMP_UNIT)
    else $error("unit bias on for a wrong channel");
  AST_X91_CH: assert property (temp_bias_x91 |-> channel_select == tsq_pkg::CH_TEMP_X91)
    else $error("large bias on for a wrong channel");
  AST_BATT_CH: assert property (battery_div_en |-> channel_select == tsq_pkg::CH_BATTERY)
    else $error("battery divider on for a wrong channel");
  AST_HOLD_NO_BIAS: assert property (sample_hold |-> !temp_bias_unit && !battery_div_en)
    else $error("bias or divider on while holding");
  AST_HOLD_PWR: assert property (sample_hold |-> adc_power_on)
    else $error("converter off while converting");
  AST_SE_DRV_OFF: assert property (sample_hold && $past(sample_hold)
    && ref_mode_select |-> drv == 4'h0)
    else $error("drivers on in single-ended conversion");
  AST_BUSY_HOLD: assert property ($rose(conv_busy) |-> adc_power_on && $past(adc_power_on))
    else $error("converter not powered before conversion");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");

  // main scenarios reached
  COV_X91: cover property (temp_bias_x91);
  COV_BATT: cover property (battery_div_en);
  COV_DIFF: cover property (sample_hold && !ref_mode_select && drv != 4'h0);
endmodule : tsq_sequencer_assertions

bind tsq_sequencer tsq_sequencer_assertions tsq_sequencer_assertions_inst (
  .clk(clk), .rst_b(rst_b), .conv_busy(conv_busy), .channel_select(channel_select),
  .ref_mode_select(ref_mode_select), .sample_hold(sample_hold), .x_drv_pos(x_drv_pos),
  .x_drv_neg(x_drv_neg), .y_drv_pos(y_drv_pos), .y_drv_neg(y_drv_neg),
  .temp_bias_unit(temp_bias_unit), .temp_bias_x91(temp_bias_x91),
  .battery_div_en(battery_div_en), .adc_power_on(adc_power_on),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);
`default_nettype wire

// ===== testbench/tsq_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host serial port; its clock only runs inside frames
module tsq_host_model (
  // system clock
  input  wire logic        clk,
  // serial pins
  output logic             sclk,
  output logic             sdin,
  input  wire logic        sdout,
  // bench view
  output logic [4:0]       edge_no,
  output logic [23:0]      rx
);
  // idle pins at time zero
  initial begin
    sclk    = 1'b0;
    sdin    = 1'b0;
    edge_no = 5'h00;
    rx      = 24'h00_0000;
  end

  // n clocks of 80 ns after lead zeros; data moves while the clock is low
  task automatic frame(input logic [7:0] cb, input int n, input int lead, input int ps);
    for (int e = 0; e < n + lead; e++) begin
      @(posedge clk);
      sdin <= (e >= lead && e < lead + 8) ? cb[7 - (e - lead)] : 1'b0;
      repeat (4) @(posedge clk);
      rx      <= {rx[22:0], sdout};
      sclk    <= 1'b1;
      edge_no <= 5'(e - lead + 1);
      repeat (5) @(posedge clk);
      sclk <= 1'b0;
      if (e - lead + 1 == ps)
        repeat (300) @(posedge clk);
    end
    // released line shows the inverse, never a stale level
    @(posedge clk);
    sdin <= ~sdin;
  endtask : frame
endmodule : tsq_host_model
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // design pins, named as the ports they meet
  logic        clk, rst_b, ce, serial_clock_in, serial_data_in, serial_data_out, conv_busy;
  logic        ref_mode_select, sample_hold, x_drv_pos, x_drv_neg, y_drv_pos, y_drv_neg;
  logic        temp_bias_unit, temp_bias_x91, battery_div_en, adc_power_on, ref_power_on;
  logic [11:0] adc_code;
  logic [2:0]  channel_select;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [4:0]  edge_no;
  logic [23:0] rx;
  int          fail_count = 0;
  int          samples_checked = 0;
  wire logic [7:0] ana = {sample_hold, temp_bias_unit, temp_bias_x91, battery_div_en,
                          x_drv_pos, x_drv_neg, y_drv_pos, y_drv_neg};

  tsq_sequencer tsq_sequencer_inst (
    .clk, .rst_b, .ce, .serial_clock_in, .serial_data_in, .serial_data_out, .conv_busy,
    .adc_code, .channel_select, .ref_mode_select, .sample_hold, .x_drv_pos, .x_drv_neg,
    .y_drv_pos, .y_drv_neg, .temp_bias_unit, .temp_bias_x91, .battery_div_en,
    .adc_power_on, .ref_power_on, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  tsq_host_model tsq_host_model_inst (
    .clk, .sclk(serial_clock_in), .sdin(serial_data_in), .sdout(serial_data_out),
    .edge_no, .rx
  );

  // 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // one counted comparison
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // write: address and data offered together, each released once taken
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw

  // read: the answer is taken at the edge where rvalid is seen
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  // touch drivers per channel, x+ x- y+ y-
  function automatic logic [3:0] drv(input logic [2:0] c);
    case (c)
      tsq_pkg::CH_Y_POS: return 4'b0011;
      tsq_pkg::CH_Z1, tsq_pkg::CH_Z2: return 4'b0110;
      tsq_pkg::CH_X_POS: return 4'b1100;
      default: return 4'b0000;
    endcase
  endfunction : drv

  // one frame, judged in acquisition and in conversion, and for 24-clock frames also on dout and after the frame
  task automatic run(input logic [7:0] cb, input int n, input int lead, input int ps);
    logic [3:0]  de;
    logic [23:0] ex;
    de = drv(cb[6:4]);
    @(posedge clk);
    adc_code <= 12'hB4D ^ {cb, 4'h0};
    fork
      tsq_host_model_inst.frame(cb, n, lead, ps);
      begin
        wait (edge_no == 5'd7);
        @(negedge clk);
        chk("acq", 32'({1'b0, cb[6:4] == tsq_pkg::CH_TEMP_UNIT,
            cb[6:4] == tsq_pkg::CH_TEMP_X91, cb[6:4] == tsq_pkg::CH_BATTERY, de}),
            32'(ana));
        wait (edge_no == 5'd12);
        @(negedge clk);
        chk("conv", 32'({4'b1000, cb[2] ? 4'h0 : de}), 32'(ana));
        chk("mux", 32'({cb[6:4], cb[2], 1'b1}),
            32'({channel_select, ref_mode_select, conv_busy}));
      end
    join
    if (n == 24) begin
      ex = cb[3] ? 24'(adc_code[11:4]) << 7 : 24'(adc_code) << 3;
      if (!cb[2]) ex = ex >> 1;
      chk("dout", 32'(ex),
          32'(rx & (cb[2] ? 24'h00_7FFF : 24'h00_3FFF)));
      repeat (8) @(posedge clk);
      chk("after", 32'({cb[0], cb[1], cb[0] ? de : 4'b0001}),
          32'({adc_power_on, ref_power_on, x_drv_pos, x_drv_neg, y_drv_pos,
          y_drv_neg}));
    end
  endtask : run

  // register reset value and a refused write
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axr(tsq_pkg::REG_CTRL, d, r);
    chk("ctrl", 32'h0000_0001, d);
    chk("ctrl resp", 32'(tsq_pkg::RESP_OKAY), 32'(r));
    axw(tsq_pkg::REG_STATUS, 32'h0000_00FF, r);
    chk("ro write", 32'(tsq_pkg::RESP_SLVERR), 32'(r));
    axw(tsq_pkg::REG_CTRL, 32'h0000_0001, r);
    chk("ctrl write", 32'(tsq_pkg::RESP_OKAY), 32'(r));
  endtask : t_regs

  // every channel, single-ended, twelve bits, power-down between frames
  task automatic t_channels();
    for (int c = 0; c < 8; c++)
      run({1'b1, 3'(c), 4'b0100}, 24, 0, 0);
  endtask : t_channels

  // differential, eight-bit pressure after idle zeros, and a stalled clock
  task automatic t_modes();
    run(8'hD1, 24, 0, 0);
    run(8'hBF, 24, 3, 0);
    run(8'hB1, 24, 0, 6);
  endtask : t_modes

  // overlapped fifteen-clock frames, then a last one commanding power-down
  task automatic t_overlap();
    logic [31:0] d;
    logic [1:0]  r;
    run(8'h91, 15, 0, 0);
    run(8'h91, 15, 0, 0);
    run(8'h90, 24, 0, 0);
    axr(tsq_pkg::REG_FRAMES, d, r);
    chk("frames", 32'd14, d);
    axr(tsq_pkg::REG_STATUS, d, r);
    chk("last byte", 32'h0000_0090, 32'(d[15:8]));
    axr(tsq_pkg::REG_RESULT, d, r);
    chk("result", 32'(adc_code), d);
  endtask : t_overlap

  // verdict, the one place where the run ends
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // watchdog: the tests need well under 10000 clocks
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    test_done();
  end

  // main sequence
  initial begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, adc_code} = '0;
    ce          = 1'b1;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    t_regs();
    t_channels();
    t_modes();
    t_overlap();
    test_done();
  end
endmodule : tb
`default_nettype wire
